// >>> src/i2c_seq_params.svh
// Constants for the bus master sequencer: offsets, fields, resets, timing.
// Assumes inclusion by the main module and the bench only.
`ifndef I2C_SEQ_PARAMS_SVH
`define I2C_SEQ_PARAMS_SVH
// Register byte offsets on the APB
`define OFS_CTRL_A 8'h00
`define OFS_CTRL_B 8'h04
`define OFS_DATA 8'h08
`define OFS_OWN 8'h0C
// control_register_a fields
`define CRA_BC_LSB 0
`define CRA_ACK_BIT 4
`define CRA_RATE_LSB 8
// control_register_b / status_register_b fields
`define CRB_MST_BIT 7
`define CRB_TRX_BIT 6
`define CRB_BB_BIT 5
`define CRB_PIN_BIT 4
`define CRB_MODE_LSB 2
`define CRB_LRB_BIT 0
// Reset values and the I2C interface mode code
`define RST_RATE 8'h04
`define RST_PIN 1'b1
`define MODE_I2C 2'h2
// Divider ticks per SCL low half and high half (t_low, t_high)
`define LOW_TICKS 2'h2
`define HIGH_TICKS 2'h2
// Bits per word when the bit count field reads 000
`define FULL_WORD 4'h8
`endif

// >>> src/i2c_seq_pkg.sv
// Types shared by the bus master sequencer.
// Assumes the params header sits beside it.
package i2c_seq_pkg;
   // Sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE   = 8'h01,
      ST_START  = 8'h02,
      ST_LOW    = 8'h04,
      ST_HIGH   = 8'h08,
      ST_WAIT   = 8'h10,
      ST_STOP_A = 8'h20,
      ST_STOP_B = 8'h40,
      ST_STOP_C = 8'h80
   } seq_state_e;
   // Sampled bus levels
   typedef struct packed {
      logic scl;
      logic sda;
   } line_in_s;
   // Open-drain pin drive
   typedef struct packed {
      logic scl_o;
      logic scl_oe;
      logic sda_o;
      logic sda_oe;
   } line_out_s;
endpackage : i2c_seq_pkg

// >>> src/i2c_pin_sync.sv
// Two-flop synchroniser for asynchronous pin levels.
// Assumes one clock; the first stage feeds only the second.
`timescale 1ns/1ps
module i2c_pin_sync #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Levels
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg; // First stage, read by second stage only
   // Lines idle high, so reset to ones
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg <= '1;
         q <= '1;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule : i2c_pin_sync

// >>> src/i2c_master_sequencer.sv
// Bus master transfer sequencer with APB register access.
// Assumes open-drain SCL/SDA resolved outside; pins are asynchronous.
//
// Behaviour
// [RQ1] Software sets ack enable, bit count 000
// [RQ2] Software loads own address, clears free format
// [RQ3] Software inits slave receiver mode, pending set
// [RQ4] Init ends before any other bus start
// [RQ5] Software checks bus free, loads address word
// [RQ6] Four ones written start, then address out
// [RQ7] One SCL low time before first fall
// [RQ8] Ninth fall raises interrupt, clears pending
// [RQ9] SCL held low while pending is zero
// [RQ10] Acked address word updates transmit select
// [RQ11] No address write during a transfer
// [RQ12] Start issued within 98.0 us of load
// [RQ13] Handler checks master, then transmit select
// [RQ14] Transmitter NACK: software generates stop
// [RQ15] Transmitter ACK: software writes next word
// [RQ16] Data write sets pending, clocks one word
// [RQ17] Data read sets pending, acks low
// [RQ18] First read after address is undefined
// [RQ19] One word plus ack per read
// [RQ20] Ack enable cleared omits ack clock
// [RQ21] Single bit clock leaves SDA high
// [RQ22] Software stops after single bit interrupt
// [RQ23] Stop command: ones, bus flag zero
// [RQ24] Bus flag follows start and stop
`timescale 1ns/1ps
`include "i2c_seq_params.svh"
module i2c_master_sequencer (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Bus pins
   input wire i2c_seq_pkg::line_in_s line_in,
   output i2c_seq_pkg::line_out_s line_out,
   // Word complete event
   output logic transfer_interrupt
);
   import i2c_seq_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers and bus condition detection
   line_in_s pins_s; // Synchronised levels
   line_in_s pins_d; // One cycle older
   i2c_pin_sync #(.W(2)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(line_in),
      .q(pins_s)
   );
   // SDA edges while SCL high are start and stop
   wire start_det = pins_d.scl & pins_s.scl & pins_d.sda & ~pins_s.sda;
   wire stop_det = pins_d.scl & pins_s.scl & ~pins_d.sda & pins_s.sda;

   ////////////////////////////////////////////////////////////////////////
   // State
   seq_state_e st_reg, st_next; // Sequencer state
   logic [1:0] ph_reg, ph_next; // Ticks in current half period
   logic [7:0] div_reg, div_next; // Rate divider
   logic [3:0] bit_reg, bit_next; // Bit index in word
   logic [7:0] sh_reg, sh_next; // data_buffer / shift register
   logic [7:0] rate_reg, rate_next; // Clock-rate field
   logic [2:0] bc_reg, bc_next; // bit_count_field
   logic ack_reg, ack_next; // Acknowledge-clock enable
   logic [1:0] mode_reg, mode_next; // interface_mode_field
   logic [1:0] swrst_reg, swrst_next; // soft_reset_code_hi/lo
   logic [6:0] own_reg, own_next; // own_address_field
   logic ffmt_reg, ffmt_next; // free_format_select
   logic mst_reg, mst_next; // master_select
   logic trx_reg, trx_next; // transmit_select
   logic bb_reg, bb_next; // bus_occupied_flag
   logic pin_reg, pin_next; // Pending-service flag
   logic lrb_reg, lrb_next; // last_received_bit
   logic addr_reg, addr_next; // Current word is the address word
   logic stopq_reg, stopq_next; // Stop requested
   logic irq_reg, irq_next; // transfer_interrupt pulse
   line_out_s lo_reg, lo_next; // Pin drive
   logic [31:0] rd_reg, rd_next; // prdata
   logic rdy_reg, rdy_next; // pready
   logic err_reg, err_next; // pslverr
   logic [3:0] nbits; // Data bits per word
   logic [3:0] total; // Data bits plus optional ack
   logic tick; // Divider enable pulse
   logic acc, wr, rd; // Completing APB access
   logic [31:0] rmux; // Read data mux
   logic hit; // Address decodes

   ////////////////////////////////////////////////////////////////////////
   // Word length and divider decode
   always_comb begin
      nbits = (bc_reg == 3'h0) ? `FULL_WORD : {1'b0, bc_reg};
      total = nbits + {3'h0, ack_reg}; // [RQ20]
      // Compare at or above: a rate lowered mid-count cannot miss a tick
      tick = (div_reg >= rate_reg);
      acc = psel & penable & rdy_reg;
      wr = acc & pwrite;
      rd = acc & ~pwrite;
   end

   // Read mux; one wait state keeps pready and prdata registered
   always_comb begin
      hit = 1'b1;
      rmux = 32'h0000_0000;
      unique case (paddr)
         `OFS_CTRL_A: begin
            rmux = {16'h0000, rate_reg, 3'h0, ack_reg, 1'b0, bc_reg};
         end
         `OFS_CTRL_B: begin
            rmux = {24'h00_0000, mst_reg, trx_reg, bb_reg, pin_reg,
               mode_reg, 1'b0, lrb_reg};
         end
         // First receive read returns stale shift contents [RQ18]
         `OFS_DATA: begin
            rmux = {24'h00_0000, sh_reg};
         end
         `OFS_OWN: begin
            rmux = {24'h00_0000, own_reg, ffmt_reg};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic: engine first, then software so a set wins
   always_comb begin
      st_next = st_reg;
      ph_next = ph_reg;
      div_next = tick ? 8'h00 : div_reg + 8'h01;
      bit_next = bit_reg;
      sh_next = sh_reg;
      rate_next = rate_reg;
      bc_next = bc_reg;
      ack_next = ack_reg;
      mode_next = mode_reg;
      swrst_next = swrst_reg;
      own_next = own_reg;
      ffmt_next = ffmt_reg;
      mst_next = mst_reg;
      trx_next = trx_reg;
      bb_next = bb_reg;
      pin_next = pin_reg;
      lrb_next = lrb_reg;
      addr_next = addr_reg;
      stopq_next = stopq_reg;
      irq_next = 1'b0;
      lo_next = lo_reg;
      lo_next.scl_o = 1'b0;
      lo_next.sda_o = 1'b0;
      rdy_next = psel & penable & ~rdy_reg;
      rd_next = rdy_next ? rmux : 32'h0000_0000;
      err_next = rdy_next & ~hit;
      // Bus flag tracks conditions; a stop ends master role
      if (start_det) begin
         bb_next = 1'b1; // [RQ24]
      end
      if (stop_det) begin
         bb_next = 1'b0; // [RQ24]
         mst_next = 1'b0;
         trx_next = 1'b0;
      end
      unique case (st_reg)
         ST_IDLE: begin
            ph_next = 2'h0;
         end
         // SDA already low with SCL high: wait t_low, then fall [RQ7]
         ST_START: begin
            if (tick) begin
               ph_next = ph_reg + 2'h1;
               if (ph_reg == `LOW_TICKS - 2'h1) begin
                  lo_next.scl_oe = 1'b1; // [RQ7]
                  ph_next = 2'h0;
                  st_next = ST_LOW;
               end
            end
         end
         // SCL low: present the bit, then release SCL
         ST_LOW: begin
            if (tick) begin
               ph_next = ph_reg + 2'h1;
               if (ph_reg == 2'h0) begin
                  if (bit_reg < nbits) begin
                     // Transmitter shifts MSB first; receiver floats [RQ21]
                     lo_next.sda_oe = trx_reg & ~sh_reg[3'h7 - bit_reg[2:0]];
                  end else begin
                     lo_next.sda_oe = ~trx_reg; // [RQ17]
                  end
               end
               if (ph_reg == `LOW_TICKS - 2'h1) begin
                  lo_next.scl_oe = 1'b0;
                  ph_next = 2'h0;
                  st_next = ST_HIGH;
               end
            end
         end
         // SCL released; a slave holding it low stretches us
         ST_HIGH: begin
            if (!pins_s.scl) begin
               ph_next = 2'h0;
            end else if (tick) begin
               ph_next = ph_reg + 2'h1;
               if (ph_reg == 2'h0) begin
                  lrb_next = pins_s.sda;
                  if (!trx_reg && bit_reg < nbits) begin
                     sh_next = {sh_reg[6:0], pins_s.sda};
                  end
               end
               if (ph_reg == `HIGH_TICKS - 2'h1) begin
                  lo_next.scl_oe = 1'b1;
                  ph_next = 2'h0;
                  bit_next = bit_reg + 4'h1;
                  st_next = ST_LOW;
                  // Last clock of the word: interrupt and hold SCL
                  if (bit_reg + 4'h1 == total) begin // [RQ19]
                     irq_next = 1'b1; // [RQ8]
                     pin_next = 1'b0; // [RQ8]
                     lo_next.sda_oe = 1'b0;
                     st_next = ST_WAIT;
                     // Direction bit decides role if acked [RQ10]
                     if (addr_reg && ack_reg && !lrb_reg) begin
                        trx_next = ~sh_reg[0]; // [RQ10]
                     end
                     addr_next = 1'b0;
                  end
               end
            end
         end
         // SCL held low until pending flag is set again [RQ9]
         ST_WAIT: begin
            lo_next.scl_oe = 1'b1; // [RQ9]
            ph_next = 2'h0;
            bit_next = 4'h0;
            if (pin_reg) begin
               st_next = stopq_reg ? ST_STOP_A : ST_LOW; // [RQ16]
            end
         end
         // Stop: SDA low under low SCL, release SCL, then SDA [RQ23]
         ST_STOP_A: begin
            lo_next.sda_oe = 1'b1;
            if (tick) begin
               ph_next = ph_reg + 2'h1;
               if (ph_reg == `LOW_TICKS - 2'h1) begin
                  lo_next.scl_oe = 1'b0;
                  ph_next = 2'h0;
                  st_next = ST_STOP_B;
               end
            end
         end
         ST_STOP_B: begin
            if (!pins_s.scl) begin
               ph_next = 2'h0;
            end else if (tick) begin
               ph_next = ph_reg + 2'h1;
               if (ph_reg == `HIGH_TICKS - 2'h1) begin
                  lo_next.sda_oe = 1'b0; // [RQ23]
                  st_next = ST_STOP_C;
               end
            end
         end
         ST_STOP_C: begin
            stopq_next = 1'b0;
            st_next = ST_IDLE;
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
      // Software accesses; sets override hardware clears
      if (wr && paddr == `OFS_CTRL_A) begin
         bc_next = pwdata[`CRA_BC_LSB +: 3];
         ack_next = pwdata[`CRA_ACK_BIT];
         rate_next = pwdata[`CRA_RATE_LSB +: 8];
      end
      if (wr && paddr == `OFS_OWN) begin
         own_next = pwdata[7:1];
         ffmt_next = pwdata[0];
      end
      if (wr && paddr == `OFS_CTRL_B) begin
         mode_next = pwdata[`CRB_MODE_LSB +: 2];
         swrst_next = pwdata[1:0];
         mst_next = pwdata[`CRB_MST_BIT];
         trx_next = pwdata[`CRB_TRX_BIT];
         if (pwdata[`CRB_PIN_BIT]) begin
            pin_next = 1'b1;
         end
         // Four ones on a free bus: start, then address word [RQ6]
         if (pwdata[7:4] == 4'hF && !bb_reg && st_reg == ST_IDLE &&
             mode_reg == `MODE_I2C) begin
            lo_next.sda_oe = 1'b1; // [RQ6]
            bit_next = 4'h0;
            addr_next = 1'b1;
            ph_next = 2'h0;
            st_next = ST_START;
         end
         // Ones with bus flag zero on a busy bus: stop [RQ23]
         if (pwdata[7:4] == 4'hD && bb_reg) begin
            stopq_next = 1'b1; // [RQ23]
         end
      end
      if (wr && paddr == `OFS_DATA) begin
         sh_next = pwdata[7:0];
         if (st_reg == ST_WAIT && mst_reg && trx_reg) begin
            pin_next = 1'b1; // [RQ16]
         end
      end
      if (rd && paddr == `OFS_DATA && st_reg == ST_WAIT && mst_reg &&
          !trx_reg) begin
         pin_next = 1'b1; // [RQ17]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= ST_IDLE;
         ph_reg <= 2'h0;
         div_reg <= 8'h00;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         rate_reg <= `RST_RATE;
         bc_reg <= 3'h0;
         ack_reg <= 1'b0;
         mode_reg <= 2'h0;
         swrst_reg <= 2'h0;
         own_reg <= 7'h00;
         ffmt_reg <= 1'b0;
         mst_reg <= 1'b0;
         trx_reg <= 1'b0;
         bb_reg <= 1'b0;
         pin_reg <= `RST_PIN;
         lrb_reg <= 1'b0;
         addr_reg <= 1'b0;
         stopq_reg <= 1'b0;
         irq_reg <= 1'b0;
         lo_reg <= '0;
         rd_reg <= 32'h0000_0000;
         rdy_reg <= 1'b0;
         err_reg <= 1'b0;
         pins_d <= '1;
      end else begin
         st_reg <= st_next;
         ph_reg <= ph_next;
         div_reg <= div_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         rate_reg <= rate_next;
         bc_reg <= bc_next;
         ack_reg <= ack_next;
         mode_reg <= mode_next;
         swrst_reg <= swrst_next;
         own_reg <= own_next;
         ffmt_reg <= ffmt_next;
         mst_reg <= mst_next;
         trx_reg <= trx_next;
         bb_reg <= bb_next;
         pin_reg <= pin_next;
         lrb_reg <= lrb_next;
         addr_reg <= addr_next;
         stopq_reg <= stopq_next;
         irq_reg <= irq_next;
         lo_reg <= lo_next;
         rd_reg <= rd_next;
         rdy_reg <= rdy_next;
         err_reg <= err_next;
         pins_d <= pins_s;
      end
   end

   assign prdata = rd_reg;
   assign pready = rdy_reg;
   assign pslverr = err_reg;
   assign line_out = lo_reg;
   assign transfer_interrupt = irq_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_start_sda_low: assert property ( // [RQ6]
      st_reg == ST_START |-> lo_reg.sda_oe && !lo_reg.scl_oe)
      else $error("start without SDA low and SCL released");
   chk_start_low_wait: assert property ( // [RQ7]
      $rose(st_reg == ST_START) && rate_reg != 8'h00 |-> !lo_reg.scl_oe [*3])
      else $error("SCL fell too soon after start");
   chk_irq_pending: assert property ( // [RQ8]
      irq_reg |-> st_reg == ST_WAIT && $past(st_reg) == ST_HIGH &&
      (!pin_reg || $past(wr)))
      else $error("interrupt outside word end or pending kept");
   chk_hold_scl: assert property ( // [RQ9]
      st_reg == ST_WAIT && !pin_reg |=> lo_reg.scl_oe)
      else $error("SCL not held while pending clear");
   chk_trx_update: assert property ( // [RQ10]
      $rose(irq_next) && addr_reg && ack_reg && !lrb_reg && !wr
      |=> trx_reg == ~$past(sh_reg[0]))
      else $error("transmit select not updated");
   chk_wr_pending: assert property ( // [RQ16]
      wr && paddr == `OFS_DATA && st_reg == ST_WAIT && mst_reg && trx_reg
      |=> pin_reg ##1 st_reg == ST_LOW)
      else $error("data write did not restart clock");
   chk_rx_ack_low: assert property ( // [RQ17]
      st_reg == ST_HIGH && !trx_reg && bit_reg == nbits && ack_reg
      |-> lo_reg.sda_oe)
      else $error("receiver did not drive ack low");
   chk_bit_bound: assert property ( // [RQ19]
      st_reg == ST_HIGH |-> bit_reg < total)
      else $error("more clocks than word length");
   chk_nack_high: assert property ( // [RQ21]
      st_reg == ST_HIGH && !trx_reg && !ack_reg && bc_reg == 3'h1
      |-> !lo_reg.sda_oe)
      else $error("single bit clock drove SDA");
   chk_bus_flag: assert property ( // [RQ24]
      start_det |=> bb_reg)
      else $error("bus flag not set on start");
   chk_bus_free: assert property ( // [RQ24]
      stop_det |=> !bb_reg && !mst_reg)
      else $error("bus flag not cleared on stop");
   cov_start: cover property ($rose(st_reg == ST_START));
   cov_word_irq: cover property (irq_reg && trx_reg);
   cov_rx_irq: cover property (irq_reg && !trx_reg && mst_reg);
   cov_stop: cover property (st_reg == ST_STOP_C);
endmodule : i2c_master_sequencer

// >>> sim/i2c_slave_model.sv
// Behavioural bus slave: acks its address, takes or sends bytes, stretches.
// Assumes pull-ups on both lines and wired-and resolution in the bench.
`timescale 1ns/1ps
module i2c_slave_model #(
   parameter logic [6:0] ADDR = 7'h3A
) (
   // Sampling clock and bus levels
   input wire logic pclk,
   input wire logic scl,
   input wire logic sda,
   // Controls from the bench
   input wire logic [7:0] tx_byte,
   input wire logic [3:0] stretch,
   // Pulls, high means line held low; one process drives each
   output logic sda_pull = 1'b0,
   output logic scl_pull = 1'b0,
   // Observation
   output logic busy = 1'b0,
   output logic ev = 1'b0,
   output logic [8:0] ev_data = 9'h000
);
   logic scl_q = 1'b1; // Previous levels
   logic sda_q = 1'b1;
   logic adr = 1'b0; // First word after start
   logic hit = 1'b0; // Addressed
   logic send = 1'b0; // Slave transmits
   logic [3:0] cnt = 4'h0; // Clock rises in this word
   logic [3:0] hold = 4'h0; // Stretch countdown
   logic [7:0] sh = 8'h00; // Shift register
   logic [7:0] tx_n = 8'h00; // Next byte to send
   ////////////////////////////////////////////////////////////////////
   // Never starts a transfer itself, so a late init cannot be hit
   always @(posedge pclk) begin
      scl_q <= scl;
      sda_q <= sda;
      ev <= 1'b0;
      scl_pull <= (hold != 4'h0);
      if (hold != 4'h0)
         hold <= hold - 4'h1;
      if (scl && scl_q && sda_q && !sda) begin
         // Start: new address word
         busy <= 1'b1;
         cnt <= 4'h0;
         adr <= 1'b1;
         hit <= 1'b0;
         send <= 1'b0;
         sda_pull <= 1'b0;
         tx_n <= tx_byte;
      end else if (scl && scl_q && !sda_q && sda) begin
         // Stop: end busy and sending, let go of SDA
         busy <= 1'b0;
         send <= 1'b0;
         sda_pull <= 1'b0;
      end else if (busy && scl && !scl_q) begin
         cnt <= cnt + 4'h1;
         if (cnt < 4'h8) begin
            sh <= {sh[6:0], sda};
         end else if (hit) begin
            // Ninth rise: word plus ack level
            ev <= 1'b1;
            ev_data <= {sh, sda};
            if (send && sda)
               send <= 1'b0; // High ack ends sending
         end
      end else if (busy && !scl && scl_q) begin
         hold <= stretch; // Slow partner holds SCL low
         if (cnt == 4'h8) begin
            sda_pull <= !send && (adr ? (sh[7:1] == ADDR) : hit);
            if (adr) begin
               hit <= (sh[7:1] == ADDR);
               send <= (sh[7:1] == ADDR) && sh[0];
            end
         end else if (cnt == 4'h9) begin
            cnt <= 4'h0;
            adr <= 1'b0;
            sda_pull <= send && !tx_n[7];
            if (send) begin
               sh <= tx_n;
               tx_n <= ~tx_n; // Next byte is the inverse
            end
         end else if (send) begin
            sda_pull <= !sh[7];
         end
      end
   end
endmodule : i2c_slave_model

// >>> sim/tb_top.sv
// Self-checking bench: APB master, slave partner, queued expectations.
// Assumes the design files and the slave model compile first.
`timescale 1ns/1ps
`include "i2c_seq_params.svh"
module tb_top;
   import i2c_seq_pkg::*;
   localparam logic [6:0] SLV = 7'h3A; // Partner address
   typedef struct packed {
      logic [31:0] data;
      logic [31:0] mask;
      logic err;
   } rd_note_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   line_in_s line_in;
   line_out_s line_out;
   logic transfer_interrupt;
   logic scl_w, sda_w, s_scl, s_sda, s_busy, s_ev;
   logic [8:0] s_ev_data;
   logic [7:0] tx_byte = 8'h00;
   logic [3:0] stretch = 4'h0;
   logic [31:0] d;
   logic [7:0] tx;
   int n_fail = 0;
   int num_checks = 0;
   int seed = 32'h7918;
   rd_note_s rd_q[$]; // Expected read answers
   rd_note_s nt;
   logic [8:0] ev_q[$]; // Expected words seen by the partner
   ////////////////////////////////////////////////////////////////////
   // 4 ns clock; rate 2 gives a 48 ns bus bit
   always #2 pclk = ~pclk;
   // Open-drain lines with pull-ups
   assign scl_w = !(line_out.scl_oe || s_scl);
   assign sda_w = !(line_out.sda_oe || s_sda);
   assign line_in = {scl_w, sda_w};
   i2c_master_sequencer u_dut (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .line_in(line_in), .line_out(line_out),
      .transfer_interrupt(transfer_interrupt));
   i2c_slave_model #(.ADDR(SLV)) u_slave (.pclk(pclk), .scl(scl_w),
      .sda(sda_w), .tx_byte(tx_byte), .stretch(stretch),
      .sda_pull(s_sda), .scl_pull(s_scl), .busy(s_busy), .ev(s_ev),
      .ev_data(s_ev_data));
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input logic [31:0] m, input string what);
      num_checks++;
      if ((got & m) !== (exp & m)) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got,
            exp);
      end
   endtask : chk
   task automatic final_report();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report
   // One APB transfer; held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] dat);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 50)
         chk(0, 1, 1, "no pready");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] dat);
      apb(1'b1, a, dat);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m, input logic err);
      rd_q.push_back('{e, m, err});
      apb(1'b0, a, 32'h0);
   endtask : rd
   // Bounded wait for the word-end pulse
   task automatic wait_int();
      int k;
      k = 0;
      while (transfer_interrupt !== 1'b1 && k < 3000) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 3000)
         chk(0, 1, 1, "no interrupt");
   endtask : wait_int
   // Stop command, then wait until the partner sees the stop
   task automatic stop_bus();
      int k;
      k = 0;
      wr(`OFS_CTRL_B, 32'hD8);
      while (s_busy !== 1'b0 && k < 3000) begin
         @(posedge pclk);
         k++;
      end
      repeat (4) @(posedge pclk);
      rd(`OFS_CTRL_B, 32'h18, 32'hFE, 0);
   endtask : stop_bus
   ////////////////////////////////////////////////////////////////////
   // Result watcher: oldest note against each answer seen
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         nt = rd_q.pop_front();
         chk(prdata, nt.data, nt.mask, "read data");
         chk({31'h0, pslverr}, {31'h0, nt.err}, 32'h1, "slave error");
      end
      if (s_ev === 1'b1)
         chk({23'h0, s_ev_data}, {23'h0, ev_q.pop_front()}, 32'h1FF,
            "bus word");
   end
   // Watchdog, far beyond the few thousand cycles needed
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      final_report();
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(`OFS_CTRL_B, 32'h10, 32'h10, 0); // Pending set out of reset
      rd(`OFS_CTRL_A, 32'h0400, 32'hFF00, 0); // Rate field default
      rd(8'h10, 32'h0, 32'hFFFFFFFF, 1); // Unmapped place
      wr(`OFS_CTRL_A, 32'h0210);
      wr(`OFS_OWN, 32'hA4);
      wr(`OFS_CTRL_B, 32'h18);
      rd(`OFS_CTRL_B, 32'h18, 32'hFE, 0);
      // Master transmit: address, one random byte, stop
      wr(`OFS_DATA, {24'h0, SLV, 1'b0});
      ev_q.push_back({SLV, 1'b0, 1'b0});
      wr(`OFS_CTRL_B, 32'hF8);
      wait_int();
      rd(`OFS_CTRL_B, 32'hE8, 32'hFF, 0);
      repeat (40) @(posedge pclk);
      chk({31'h0, scl_w}, 32'h0, 32'h1, "clock not held");
      d = $random(seed);
      ev_q.push_back({d[7:0], 1'b0});
      wr(`OFS_DATA, {24'h0, d[7:0]});
      wait_int();
      rd(`OFS_CTRL_B, 32'hE8, 32'hFF, 0);
      stop_bus();
      // Nobody answers: direction kept, last bit high
      wr(`OFS_DATA, {24'h0, ~SLV, 1'b1});
      wr(`OFS_CTRL_B, 32'hF8);
      wait_int();
      rd(`OFS_CTRL_B, 32'hE9, 32'hFF, 0);
      stop_bus();
      // Master receive from a slow partner, ended by a single bit
      d = $random(seed);
      tx = d[15:8];
      stretch <= 4'h9;
      tx_byte <= tx;
      wr(`OFS_DATA, {24'h0, SLV, 1'b1});
      ev_q.push_back({SLV, 1'b1, 1'b0});
      wr(`OFS_CTRL_B, 32'hF8);
      wait_int();
      rd(`OFS_CTRL_B, 32'hA8, 32'hFF, 0);
      ev_q.push_back({tx, 1'b0});
      rd(`OFS_DATA, 32'h0, 32'h0, 0);
      wait_int();
      wr(`OFS_CTRL_A, 32'h0200);
      ev_q.push_back({~tx, 1'b1});
      rd(`OFS_DATA, {24'h0, tx}, 32'hFF, 0);
      wait_int();
      wr(`OFS_CTRL_A, 32'h0201);
      rd(`OFS_DATA, {24'h0, ~tx}, 32'hFF, 0);
      wait_int();
      stop_bus();
      chk(ev_q.size(), 32'h0, 32'hFF, "words left");
      final_report();
   end
endmodule : tb_top
